// *** shared/tws_pkg.sv ***
/*
 Constants, status codes, register map and state encoding for the two-wire
 slave receiver. Assumes a 50 MHz pclk and an APB master with 32-bit data.
*/
// Overview of operation
// - status codes read with prescaler bits zero or masked to zero
// - respond only when received 7-bit address equals own address upper bits or is an enabled general call
// - own address bit 0 enables general call response, clear ignores it
// - await own or general call address; direction 0 receive, 1 transmit (here direction 1 is not acked; only a one-cycle slave_transmit_mode pulse)
// - after own address with write, set step flag and valid status code
// - entering receive after lost arbitration reports the arbitration-lost codes
// - ack enable cleared mid transfer gives not-acknowledge after next data byte
// - ack enable zero: no address ack, keep monitoring, resume when set
// - in deep sleep still recognise and ack address using bus clock edges
// - sleep address match wakes part, holds clock low until flag cleared
// - data register need not hold last bus byte after waking
// - after address acked, resuming with ack enable clear nacks next byte
package tws_pkg;
    // ==========================================
    // register map (byte addresses)
    localparam logic [7:0] ADR_OWN = 8'h00;
    localparam logic [7:0] ADR_CTL = 8'h04;
    localparam logic [7:0] ADR_STS = 8'h08;
    localparam logic [7:0] ADR_DAT = 8'h0c;
    localparam logic [7:0] ADR_IRQ = 8'h10;
    localparam logic [7:0] ADR_MSK = 8'h14;
    // ==========================================
    // control field positions
    localparam int CTL_FLAG = 7;
    localparam int CTL_ACK = 6;
    localparam int CTL_STA = 5;
    localparam int CTL_STO = 4;
    localparam int CTL_WCOL = 3;
    localparam int CTL_EN = 2;
    localparam int CTL_IE = 0;
    // ==========================================
    // status register layout and codes
    localparam logic [7:0] CODE_MASK = 8'hf8;
    localparam logic [1:0] PRESC_RST = 2'h0;
    localparam logic [7:0] SC_OWN_W_ACK = 8'h60;
    localparam logic [7:0] SC_ARB_OWN_W = 8'h68;
    localparam logic [7:0] SC_GC_ACK = 8'h70;
    localparam logic [7:0] SC_ARB_GC = 8'h78;
    localparam logic [7:0] SC_DATA_ACK = 8'h80;
    localparam logic [7:0] SC_DATA_NACK = 8'h88;
    localparam logic [7:0] SC_GC_DATA_ACK = 8'h90;
    localparam logic [7:0] SC_GC_DATA_NACK = 8'h98;
    localparam logic [7:0] SC_STOP_RS = 8'ha0;
    localparam logic [7:0] SC_NO_INFO = 8'hf8;
    // ==========================================
    // misc
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'd8;
    localparam logic [7:0] OWN_RST = 8'h00;
    localparam int IRQ_W = 3;
    localparam int IRQ_ADDR = 0;
    localparam int IRQ_DATA = 1;
    localparam int IRQ_STOP = 2;
    typedef enum logic [5:0] {
        TWS_IDLE = 6'b000001,
        TWS_ADDR = 6'b000010,
        TWS_AACK = 6'b000100,
        TWS_DATA = 6'b001000,
        TWS_DACK = 6'b010000,
        TWS_HOLD = 6'b100000
    } tws_state_t;
endpackage : tws_pkg

// *** shared/tws_bus_if.sv ***
/*
 Bus event bundle between the pin synchroniser and its users.
 Assumes every signal is on pclk, already synchronised.
*/
`timescale 1ns/1ns
interface tws_bus_if;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_lvl;
    modport src (output scl_rise, output scl_fall, output start_det, output stop_det,
                 output sda_lvl);
    modport dst (input scl_rise, input scl_fall, input start_det, input stop_det,
                 input sda_lvl);
endinterface : tws_bus_if

// *** hdl/tws_sync.sv ***
/*
 Two-flop synchroniser for scl and sda plus edge, start and stop detection.
 Assumes the bus pins are asynchronous to pclk and slower than pclk / 4.
*/
`timescale 1ns/1ns
module tws_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl_in,
    input wire logic sda_in,
    tws_bus_if.src ev
);
    // bit 0 scl, bit 1 sda; bus idles high
    logic [1:0] meta_ff;
    logic [1:0] sync_ff;
    logic [1:0] prev_ff;

    // ==========================================
    // synchroniser; meta_ff feeds only sync_ff
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 2'h3;
            sync_ff <= 2'h3;
            prev_ff <= 2'h3;
        end else begin
            meta_ff <= {sda_in, scl_in};
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // ==========================================
    // edges and bus conditions
    assign ev.scl_rise = sync_ff[0] & ~prev_ff[0];
    assign ev.scl_fall = ~sync_ff[0] & prev_ff[0];
    assign ev.start_det = sync_ff[0] & prev_ff[0] & prev_ff[1] & ~sync_ff[1];
    assign ev.stop_det = sync_ff[0] & prev_ff[0] & ~prev_ff[1] & sync_ff[1];
    assign ev.sda_lvl = sync_ff[1];
endmodule : tws_sync

// *** hdl/tws_rx.sv ***
/*
 Bit counter and shift register for one received byte.
 Assumes clr is pulsed by the controller after each acknowledge bit.
*/
`timescale 1ns/1ns
module tws_rx (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    tws_bus_if.dst ev,
    output logic [7:0] rx_byte,
    output logic [3:0] bit_cnt
);
    import tws_pkg::*;

    // ==========================================
    // sample sda on scl rise, msb first; count saturates at a full byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_byte <= 8'h00;
            bit_cnt <= 4'h0;
        end else if (clr || ev.start_det) begin
            bit_cnt <= 4'h0;
        end else if (ev.scl_rise && bit_cnt != BITS_PER_BYTE) begin
            rx_byte <= {rx_byte[6:0], ev.sda_lvl};
            bit_cnt <= bit_cnt + 4'h1;
        end
    end
endmodule : tws_rx

// *** hdl/tws_top.sv ***
/*
 Two-wire slave receiver with APB register access and a masked interrupt.
 Assumes an external master transmitter, open-drain pins resolved outside,
 and a same-clock arbitration-lost level from the master logic.
*/
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module tws_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic deep_sleep,
    input wire logic arb_lost_in,
    output logic wake_req,
    output logic slave_transmit_mode,
    output logic irq
);
    import tws_pkg::*;

    // ==========================================
    // declarations
    tws_bus_if ev ();
    tws_state_t state_ff;
    logic [7:0] rx_byte;
    logic [3:0] bit_cnt;
    logic [7:0] own_bus_address_ff;
    logic step_done_flag_ff;
    logic ack_enable_ff;
    logic start_request_ff;
    logic stop_request_ff;
    logic write_collision_ff;
    logic interface_enable_ff;
    logic irq_enable_ff;
    logic [7:0] code_ff;
    logic [1:0] presc_ff;
    logic [7:0] bus_data_byte_ff;
    logic [IRQ_W-1:0] irq_sts_ff;
    logic [IRQ_W-1:0] irq_msk_ff;
    logic sda_drv_ff;
    logic gc_ff;
    logic nack_ff;
    logic addressed_ff;
    logic wake_ff;
    logic rd_dir_pulse_ff;
    logic [31:0] prdata_ff;
    logic slverr_ff;
    logic wr_en;
    logic setup;
    logic byte_end;
    logic ack_end;
    logic own_hit;
    logic gc_hit;
    logic ev_addr;
    logic ev_data;
    logic ev_stop;
    logic flag_clr;
    logic [IRQ_W-1:0] irq_set;

    // general call hit gated by the enable bit in own address bit 0
    function automatic logic gc_match(input logic [7:0] b, input logic [7:0] own);
        gc_match = (b[7:1] == GC_ADDR) && own[0];
    endfunction : gc_match

    // register hit decode, used only by the error answer; the read mux decodes paddr itself
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == ADR_OWN) || (a == ADR_CTL) || (a == ADR_STS) ||
                      (a == ADR_DAT) || (a == ADR_IRQ) || (a == ADR_MSK);
    endfunction : addr_mapped

    // ==========================================
    // sub blocks
    tws_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    tws_rx u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .clr(ack_end),
        .ev(ev),
        .rx_byte(rx_byte),
        .bit_cnt(bit_cnt)
    );

    // ==========================================
    // bus decode and events
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign byte_end = ev.scl_fall && (bit_cnt == BITS_PER_BYTE);
    assign ack_end = ev.scl_fall && (state_ff == TWS_AACK || state_ff == TWS_DACK);
    assign own_hit = rx_byte[7:1] == own_bus_address_ff[7:1];
    assign gc_hit = gc_match(rx_byte, own_bus_address_ff);
    assign ev_addr = ack_end && state_ff == TWS_AACK;
    assign ev_data = ack_end && state_ff == TWS_DACK;
    assign ev_stop = addressed_ff && state_ff != TWS_HOLD && (ev.stop_det || ev.start_det);
    // a software write of one clears the flag
    assign flag_clr = wr_en && paddr == ADR_CTL && pwdata[CTL_FLAG];
    assign irq_set = {ev_stop, ev_data, ev_addr};

    // ==========================================
    // main receive sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= TWS_IDLE;
        end else if (!interface_enable_ff) begin
            state_ff <= TWS_IDLE;
        end else if (ev.start_det && state_ff != TWS_HOLD) begin
            state_ff <= TWS_ADDR;
        end else if (ev.stop_det && state_ff != TWS_HOLD) begin
            state_ff <= TWS_IDLE;
        end else begin
            case (state_ff)
                TWS_IDLE: state_ff <= TWS_IDLE;
                TWS_ADDR: begin
                    // disabled ack leaves us idle but still watching for starts
                    if (byte_end) begin
                        if (ack_enable_ff && (own_hit || gc_hit) && !rx_byte[0]) begin
                            state_ff <= TWS_AACK;
                        end else begin
                            state_ff <= TWS_IDLE;
                        end
                    end
                end
                TWS_AACK: if (ev.scl_fall) state_ff <= TWS_HOLD;
                TWS_DATA: if (byte_end) state_ff <= TWS_DACK;
                TWS_DACK: if (ev.scl_fall) state_ff <= TWS_HOLD;
                TWS_HOLD: begin
                    // leave only once software has cleared the flag or disabled the interface
                    if (!step_done_flag_ff) begin
                        state_ff <= nack_ff ? TWS_IDLE : TWS_DATA;
                    end
                end
                default: state_ff <= TWS_IDLE;
            endcase
        end
    end

    // ==========================================
    // sda drive for acknowledge bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_drv_ff <= 1'b0;
            nack_ff <= 1'b0;
        end else if (state_ff == TWS_ADDR && byte_end) begin
            sda_drv_ff <= interface_enable_ff && ack_enable_ff && (own_hit || gc_hit) &&
                          !rx_byte[0];
            nack_ff <= 1'b0;
        end else if (state_ff == TWS_DATA && byte_end) begin
            // ack enable sampled as the byte ends, so clearing it mid byte nacks it
            sda_drv_ff <= ack_enable_ff;
            nack_ff <= !ack_enable_ff;
        end else if (ack_end || ev.start_det || ev.stop_det) begin
            sda_drv_ff <= 1'b0;
        end
    end

    // ==========================================
    // addressing context and transmit-direction pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gc_ff <= 1'b0;
            addressed_ff <= 1'b0;
            rd_dir_pulse_ff <= 1'b0;
        end else begin
            rd_dir_pulse_ff <= state_ff == TWS_ADDR && byte_end && ack_enable_ff &&
                           interface_enable_ff && own_hit && rx_byte[0];
            if (state_ff == TWS_ADDR && byte_end) begin
                gc_ff <= gc_hit && !own_hit;
            end
            if (ev_addr) begin
                addressed_ff <= 1'b1;
            end else if (state_ff == TWS_IDLE || ev_stop) begin
                addressed_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // status code; prescaler bits live beside it in the low bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_ff <= SC_NO_INFO;
        end else if (ev_addr) begin
            if (gc_ff) begin
                code_ff <= arb_lost_in ? SC_ARB_GC : SC_GC_ACK;
            end else begin
                code_ff <= arb_lost_in ? SC_ARB_OWN_W : SC_OWN_W_ACK;
            end
        end else if (ev_data) begin
            if (gc_ff) begin
                code_ff <= nack_ff ? SC_GC_DATA_NACK : SC_GC_DATA_ACK;
            end else begin
                code_ff <= nack_ff ? SC_DATA_NACK : SC_DATA_ACK;
            end
        end else if (ev_stop) begin
            code_ff <= SC_STOP_RS;
        end else if (state_ff == TWS_HOLD && !step_done_flag_ff) begin
            code_ff <= SC_NO_INFO;
        end
    end

    // ==========================================
    // step flag: hardware set wins over a same-cycle software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_done_flag_ff <= 1'b0;
        end else if (ev_addr || ev_data || ev_stop) begin
            step_done_flag_ff <= 1'b1;
        end else if (flag_clr) begin
            step_done_flag_ff <= 1'b0;
        end
    end

    // ==========================================
    // wake request: raised on an address taken while asleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_ff <= 1'b0;
        end else if (ev_addr && deep_sleep) begin
            wake_ff <= 1'b1;
        end else if (flag_clr) begin
            wake_ff <= 1'b0;
        end
    end

    // ==========================================
    // writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_bus_address_ff <= OWN_RST;
            ack_enable_ff <= 1'b0;
            start_request_ff <= 1'b0;
            stop_request_ff <= 1'b0;
            interface_enable_ff <= 1'b0;
            irq_enable_ff <= 1'b0;
            presc_ff <= PRESC_RST;
            irq_msk_ff <= '0;
        end else if (wr_en) begin
            case (paddr)
                ADR_OWN: own_bus_address_ff <= pwdata[7:0];
                ADR_CTL: begin
                    ack_enable_ff <= pwdata[CTL_ACK];
                    // master requests are only stored for read-back; no logic here acts on them
                    start_request_ff <= pwdata[CTL_STA];
                    stop_request_ff <= pwdata[CTL_STO];
                    interface_enable_ff <= pwdata[CTL_EN];
                    irq_enable_ff <= pwdata[CTL_IE];
                end
                ADR_STS: presc_ff <= pwdata[1:0];
                ADR_MSK: irq_msk_ff <= pwdata[IRQ_W-1:0];
                default: presc_ff <= presc_ff;
            endcase
        end
    end

    // ==========================================
    // data byte and write collision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_data_byte_ff <= 8'h00;
            write_collision_ff <= 1'b0;
        end else if (state_ff == TWS_DATA && byte_end) begin
            // only data bytes land here; address bytes seen asleep never do
            bus_data_byte_ff <= rx_byte;
        end else if (wr_en && paddr == ADR_DAT) begin
            write_collision_ff <= !step_done_flag_ff;
            if (step_done_flag_ff) begin
                bus_data_byte_ff <= pwdata[7:0];
            end
        end
    end

    // ==========================================
    // sticky interrupt causes, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sts_ff <= '0;
        end else if (wr_en && paddr == ADR_IRQ) begin
            irq_sts_ff <= (irq_sts_ff & ~pwdata[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_sts_ff <= irq_sts_ff | irq_set;
        end
    end

    // ==========================================
    // apb read data and error captured in the setup cycle, zero wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
        end else if (setup) begin
            slverr_ff <= !addr_mapped(paddr);
            case (paddr)
                ADR_OWN: prdata_ff <= {24'h0, own_bus_address_ff};
                ADR_CTL: prdata_ff <= {24'h0, step_done_flag_ff, ack_enable_ff,
                                       start_request_ff, stop_request_ff,
                                       write_collision_ff, interface_enable_ff,
                                       1'b0, irq_enable_ff};
                // software masks the low bits to see the bare code
                ADR_STS: prdata_ff <= {24'h0, (code_ff & CODE_MASK) | {6'h0, presc_ff}};
                ADR_DAT: prdata_ff <= {24'h0, bus_data_byte_ff};
                ADR_IRQ: prdata_ff <= {29'h0, irq_sts_ff};
                ADR_MSK: prdata_ff <= {29'h0, irq_msk_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // outputs; pins are open drain, out tied low
    assign prdata = prdata_ff;
    assign pready = psel & penable;
    assign pslverr = psel & penable & slverr_ff;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = state_ff == TWS_HOLD; // long wake-ups block the bus
    assign sda_oe = sda_drv_ff;
    assign wake_req = wake_ff;
    assign slave_transmit_mode = rd_dir_pulse_ff;
    assign irq = (|(irq_sts_ff & irq_msk_ff)) | (step_done_flag_ff & irq_enable_ff);

    // ==========================================
    // assertions
    a_flag_after_event: assert property (@(posedge pclk) disable iff (!presetn)
        (ev_addr || ev_data) |=> step_done_flag_ff && scl_oe)
        else $error("flag or clock hold missing after acknowledge");
    a_hold_until_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == TWS_HOLD && !step_done_flag_ff) |=> !scl_oe)
        else $error("clock still held after flag clear");
    a_data_nack: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == TWS_DATA && byte_end && !ack_enable_ff && !ev.start_det &&
         !ev.stop_det) |=> !sda_oe ##1 nack_ff)
        else $error("data byte acked with ack enable clear");
    a_data_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == TWS_DATA && byte_end && ack_enable_ff && interface_enable_ff &&
         !ev.start_det && !ev.stop_det) |=> sda_oe && state_ff == TWS_DACK)
        else $error("data byte not acked with ack enable set");
    a_addr_mismatch: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == TWS_ADDR && byte_end && !own_hit && !gc_hit) |=> !sda_oe)
        else $error("foreign address acknowledged");
    a_gc_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == TWS_ADDR && byte_end && rx_byte[7:1] == GC_ADDR &&
         !own_bus_address_ff[0] && !own_hit) |=> !sda_oe)
        else $error("general call acked while disabled");
    a_ack_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == TWS_ADDR && byte_end && !ack_enable_ff) |=> !sda_oe ##1 !sda_oe)
        else $error("address acked with ack enable clear");
    a_read_dir: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == TWS_ADDR && byte_end && rx_byte[0] && !ev.start_det &&
         interface_enable_ff) |=> state_ff == TWS_IDLE && !sda_oe)
        else $error("read direction entered receive");
    a_arb_code: assert property (@(posedge pclk) disable iff (!presetn)
        (ev_addr && arb_lost_in && !gc_ff) |=> code_ff == SC_ARB_OWN_W)
        else $error("arbitration-lost code missing");
    a_wake_holds: assert property (@(posedge pclk) disable iff (!presetn)
        wake_ff |-> scl_oe && step_done_flag_ff)
        else $error("wake without clock hold");
endmodule : tws_top

// *** dv/tws_master_model.sv ***
/* master transmitter on the far side of the bus.
   assumes the bench ands each line with the slave's pull-low enable. */
`timescale 1ns/1ns
module tws_master_model (
    output logic scl_m,
    output logic sda_m,
    input wire logic scl,
    input wire logic sda
);
    // ==========
    // lines released, clock stands high outside frames
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic start_c();
        sda_m <= 1'b0;
        #80 scl_m <= 1'b0;
    endtask : start_c
    // msb first, ninth bit left released; waits out clock stretching
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            #40 sda_m <= (i > 0) ? b[i-1] : 1'b1;
            #40 scl_m <= 1'b1;
            wait (scl === 1'b1);
            if (i == 0) ack = !sda;
            #80 scl_m <= 1'b0;
        end
    endtask : send
    task automatic stop_c();
        #40 sda_m <= 1'b0;
        #40 scl_m <= 1'b1;
        wait (scl === 1'b1);
        #80 sda_m <= 1'b1;
        #80;
    endtask : stop_c
endmodule : tws_master_model

// *** dv/two_wire_slave_receiver_tb.sv ***
/* self-checking bench for the slave receiver.
   assumes the master model and pulled-up open-drain lines. */
`timescale 1ns/1ns
module two_wire_slave_receiver_tb;
    import tws_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic deep_sleep = 1'b0, arb_lost_in = 1'b0, ack, err_seen;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, scl_oe, sda_oe, wake_req, stm, irq, scl_m, sda_m;
    int err_total = 0, checks = 0;
    int stm_cnt = 0;
    wire logic scl = scl_m & ~scl_oe;
    wire logic sda = sda_m & ~sda_oe;
    // ==========
    always #10 pclk = ~pclk;
    // read-direction pulses are one cycle wide, so count them
    always @(posedge pclk) if (stm) stm_cnt <= stm_cnt + 1;
    tws_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(), .sda_oe(sda_oe), .deep_sleep(deep_sleep), .arb_lost_in(arb_lost_in),
        .wake_req(wake_req), .slave_transmit_mode(stm), .irq(irq));
    tws_master_model mst (.scl_m(scl_m), .sda_m(sda_m), .scl(scl), .sda(sda));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // held until pready is sampled; the #1 lets that edge's updates land
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    // byte plus slack for the slave's synchroniser
    task automatic sb(input logic [7:0] b);
        mst.send(b, ack);
        #200;
    endtask : sb
    task automatic frame(input logic [7:0] own, input logic [7:0] ctl, input logic [7:0] ab);
        apb(1'b1, ADR_OWN, {24'h0, own});
        apb(1'b1, ADR_CTL, {24'h0, ctl});
        mst.start_c();
        sb(ab);
    endtask : frame
    task automatic t_receive();
        frame(8'h53, 8'h45, 8'h52);
        apb(1'b0, ADR_STS, 32'h0);
        chk(q & CODE_MASK, SC_OWN_W_ACK);
        chk({ack, irq, scl_oe}, 3'b111);
        apb(1'b1, ADR_CTL, 32'hc5);
        sb(8'ha5);
        apb(1'b0, ADR_DAT, 32'h0);
        chk({ack, q[7:0]}, 9'h1a5);
        apb(1'b1, ADR_CTL, 32'h85);
        sb(8'h3c);
        apb(1'b0, ADR_STS, 32'h0);
        chk({ack, q[7:3], 3'h0}, {1'b0, SC_DATA_NACK});
        apb(1'b1, ADR_CTL, 32'hc5);
        mst.stop_c();
        // interrupt: masked, unmasked, cleared
        apb(1'b1, ADR_CTL, 32'h84);
        apb(1'b1, ADR_MSK, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, ADR_MSK, 32'h7);
        chk(irq, 1'b1);
        apb(1'b1, ADR_IRQ, 32'h7);
        chk(irq, 1'b0);
    endtask : t_receive
    // own, control, address byte, expected code (00 means not acked)
    task automatic t_filter();
        logic [31:0] tab [8] = '{32'h53455000, 32'h53450070, 32'h52450000, 32'h52455300,
            32'h52055200, 32'h52455260, 32'h52455268, 32'h53450078};
        for (int i = 0; i < 8; i++) begin
            arb_lost_in <= (i > 5);
            frame(tab[i][31:24], tab[i][23:16], tab[i][15:8]);
            apb(1'b0, ADR_STS, 32'h0);
            chk(ack, tab[i][7:0] != 8'h00);
            if (tab[i][7:0] != 8'h00) chk(q & CODE_MASK, tab[i][7:0]);
            apb(1'b1, ADR_CTL, 32'hc5);
            mst.stop_c();
        end
        arb_lost_in <= 1'b0;
        chk(stm_cnt, 32'h1);
    endtask : t_filter
    task automatic t_sleep();
        deep_sleep <= 1'b1;
        frame(8'h52, 8'h45, 8'h52);
        #2000;
        chk({ack, wake_req, scl}, 3'b110);
        apb(1'b1, ADR_CTL, 32'hc5);
        deep_sleep <= 1'b0;
        chk(wake_req, 1'b0);
        mst.stop_c();
    endtask : t_sleep
    task automatic summarize();
        $display("mismatches %0d, checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    // ==========
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADR_STS, 32'h0);
        chk(q, 32'hf8);
        apb(1'b0, 8'h40, 32'h0);
        chk(err_seen, 1'b1);
        chk(q, 32'h0);
        t_receive();
        t_filter();
        t_sleep();
        summarize();
    end
    // a hang counts against the run
    initial begin
        #1000000;
        err_total++;
        summarize();
    end
endmodule : two_wire_slave_receiver_tb
